// File: src/scp_consts.svh
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH

// ****************************************************************
// Frame layout
// ****************************************************************
`define SCP_CNT_ZERO      5'd0
`define SCP_CNT_ONE       5'd1
`define SCP_HDR_LAST      5'd7
`define SCP_FRAME_LAST    5'd23
`define SCP_MEM_SEL_BIT   7
`define SCP_DIR_BIT       6
`define SCP_ADDR_MSB      5

// ****************************************************************
// Address map
// ****************************************************************
`define SCP_STROBE_MAX    6'h0e
`define SCP_REG_BASE      6'h10
`define SCP_REG_COUNT     33
`define SCP_REG_END       6'h31
`define SCP_ST_NOP        6'h00
`define SCP_ST_OSC_START  6'h01
`define SCP_ST_FLUSH_TX   6'h09

// ****************************************************************
// Status byte fields and reset values
// ****************************************************************
`define SCP_SB_XOSC       6
`define SCP_SB_UNDERFLOW  5
`define SCP_SB_CIPHER     4
`define SCP_SB_TX_ACTIVE  3
`define SCP_SB_LOCK       2
`define SCP_SB_LEVEL_OK   1
`define SCP_SB_RESET      8'h00
`define SCP_WORD_RESET    16'h0000

// ****************************************************************
// Timing
// ****************************************************************
`define SCP_CLK_NS        8
`define SCP_LEVEL_OK_NS   128000

`endif

// File: src/scp_pkg.sv
package scp_pkg;

    // One register write handed to the core
    typedef struct packed {
        logic [5:0]  addr;
        logic [15:0] data;
    } scp_wr_type;

endpackage : scp_pkg

// File: src/scp_port.sv
// Overview of operation
// - Slave port, every field shifted MSB first
// - Six-bit address: registers and strobes
// - Second header bit: zero write, one read
// - Six address bits, then 16 data bits
// - Read data leaves during the 16 data clocks
// - Serial input sampled on rising serial clock
// - Register loads only after the last bit
// - Back-to-back accesses within one select
// - Register contents survive power-down
// - Registers may be written in any order
// - Status byte returned during the header byte
// - Status bit 6 shows oscillator running
// - Underflow bit sticky until transmit flush strobe
// - Bits 4 and 3 show cipher and transmit
// - Status bit 2 shows synthesizer lock
// - Bit 1 set after 128 us of reception
// - Strobe header has no data, fires last fall
// - Oscillator off: only oscillator start accepted
`timescale 1ns/100ps
`default_nettype none
`include "scp_consts.svh"

module scp_port
    import scp_pkg::*;
#(
    parameter int LEVEL_OK_CYCLES = `SCP_LEVEL_OK_NS / `SCP_CLK_NS
) (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        serial_clock,
    input  wire logic        chip_select_n,
    input  wire logic        serial_in,
    output logic             serial_out,
    output logic             serial_out_oe_n,
    input  wire logic        crystal_running,
    input  wire logic        cipher_engine_busy,
    input  wire logic        tx_active,
    input  wire logic        pll_locked,
    input  wire logic        rx_enabled,
    input  wire logic        tx_underflow_event,
    output logic             cfg_wr_valid,
    output scp_wr_type       cfg_wr,
    output logic             strobe_valid,
    output logic [5:0]       strobe_code,
    output logic [7:0]       status_byte
);

    // ************************************************************
    // Link domain: frame shifter on the serial clock
    // ************************************************************
    // Select high restarts the frame; the serial clock may be idle
    logic             link_clr;
    logic [4:0]       bit_cnt_reg, bit_cnt_next;
    logic [7:0]       hdr_reg, hdr_next;
    logic [15:0]      dat_reg, dat_next;
    logic             strb_req_reg, strb_req_next;
    logic [5:0]       strb_code_reg, strb_code_next;
    logic             wr_tog_reg, wr_tog_next;
    scp_wr_type       wr_hold_reg, wr_hold_next;
    logic [15:0]      reg_file [`SCP_REG_COUNT];
    logic             rf_we;
    logic [5:0]       rf_idx;
    logic [7:0]       hdr_full;
    logic             strobe_hdr;
    logic             rd_hit;
    logic [5:0]       rd_idx;
    logic             so_reg, so_next;
    logic             strb_fall_reg;
    logic [7:0]       stat_meta_reg, stat_sync_reg;

    assign link_clr = sys_rst | chip_select_n;
    assign hdr_full = {hdr_reg[6:0], serial_in};
    // Register write with address in the strobe window
    assign strobe_hdr = !hdr_full[`SCP_MEM_SEL_BIT]
                      && !hdr_full[`SCP_DIR_BIT]
                      && hdr_full[`SCP_ADDR_MSB:0] <= `SCP_STROBE_MAX;

    // Next state of the shifter and of the crossing holders
    always_comb begin
        bit_cnt_next   = bit_cnt_reg + `SCP_CNT_ONE;
        hdr_next       = hdr_reg;
        dat_next       = dat_reg;
        strb_req_next  = strb_req_reg;
        strb_code_next = strb_code_reg;
        wr_tog_next    = wr_tog_reg;
        wr_hold_next   = wr_hold_reg;
        rf_we          = 1'b0;
        rf_idx         = hdr_reg[`SCP_ADDR_MSB:0] - `SCP_REG_BASE;
        if (bit_cnt_reg <= `SCP_HDR_LAST) begin
            hdr_next = hdr_full;
        end else begin
            dat_next = {dat_reg[14:0], serial_in};
        end
        if (bit_cnt_reg == `SCP_HDR_LAST && strobe_hdr) begin
            // No data follows a strobe; the next bit opens a header
            bit_cnt_next   = `SCP_CNT_ZERO;
            strb_req_next  = ~strb_req_reg;
            strb_code_next = hdr_full[`SCP_ADDR_MSB:0];
        end
        if (bit_cnt_reg == `SCP_FRAME_LAST) begin
            bit_cnt_next = `SCP_CNT_ZERO;
            // Word loads only with its last bit in hand
            if (!hdr_reg[`SCP_MEM_SEL_BIT] && !hdr_reg[`SCP_DIR_BIT]
                && hdr_reg[`SCP_ADDR_MSB:0] >= `SCP_REG_BASE
                && hdr_reg[`SCP_ADDR_MSB:0] < `SCP_REG_END) begin
                rf_we = 1'b1;
                wr_tog_next = ~wr_tog_reg;
                wr_hold_next.addr = hdr_reg[`SCP_ADDR_MSB:0];
                wr_hold_next.data = {dat_reg[14:0], serial_in};
            end
        end
    end

    // Frame state, cleared whenever select rises
    always_ff @(posedge serial_clock or posedge link_clr) begin
        if (link_clr) begin
            bit_cnt_reg <= `SCP_CNT_ZERO;
            hdr_reg     <= `SCP_SB_RESET;
            dat_reg     <= `SCP_WORD_RESET;
        end else begin
            bit_cnt_reg <= bit_cnt_next;
            hdr_reg     <= hdr_next;
            dat_reg     <= dat_next;
        end
    end

    // Crossing holders and register array; select does not clear
    // them, so a pending event is never lost when the frame ends
    always_ff @(posedge serial_clock or posedge sys_rst) begin
        if (sys_rst) begin
            strb_req_reg  <= 1'b0;
            strb_code_reg <= `SCP_ST_NOP;
            wr_tog_reg    <= 1'b0;
            wr_hold_reg   <= '0;
            for (int i = 0; i < `SCP_REG_COUNT; i++) begin
                reg_file[i] <= `SCP_WORD_RESET;
            end
        end else begin
            strb_req_reg  <= strb_req_next;
            strb_code_reg <= strb_code_next;
            wr_tog_reg    <= wr_tog_next;
            wr_hold_reg   <= wr_hold_next;
            // Held through power-down; only the core reset clears
            if (rf_we) begin
                reg_file[rf_idx] <= wr_hold_next.data;
            end
        end
    end

    // Status byte brought over as levels, two flops per bit
    always_ff @(posedge serial_clock or posedge sys_rst) begin
        if (sys_rst) begin
            stat_meta_reg <= `SCP_SB_RESET;
            stat_sync_reg <= `SCP_SB_RESET;
        end else begin
            stat_meta_reg <= status_byte;
            stat_sync_reg <= stat_meta_reg;
        end
    end

    // ************************************************************
    // Link domain: output shifter on the falling edge
    // ************************************************************
    assign rd_idx = hdr_reg[`SCP_ADDR_MSB:0] - `SCP_REG_BASE;
    assign rd_hit = !hdr_reg[`SCP_MEM_SEL_BIT] && hdr_reg[`SCP_DIR_BIT]
                  && hdr_reg[`SCP_ADDR_MSB:0] >= `SCP_REG_BASE
                  && hdr_reg[`SCP_ADDR_MSB:0] < `SCP_REG_END;

    // Status during the header, then the addressed word on a read
    always_comb begin
        so_next = 1'b0;
        if (bit_cnt_reg != `SCP_CNT_ZERO && bit_cnt_reg <= `SCP_HDR_LAST) begin
            so_next = stat_sync_reg[3'(`SCP_HDR_LAST - bit_cnt_reg)];
        end else if (bit_cnt_reg > `SCP_HDR_LAST && rd_hit) begin
            so_next = reg_file[rd_idx][4'(`SCP_FRAME_LAST - bit_cnt_reg)];
        end
    end

    always_ff @(negedge serial_clock or posedge link_clr) begin
        if (link_clr) begin
            so_reg <= 1'b0;
        end else begin
            so_reg <= so_next;
        end
    end

    // Strobe fires on the falling edge that closes its byte
    always_ff @(negedge serial_clock or posedge sys_rst) begin
        if (sys_rst) begin
            strb_fall_reg <= 1'b0;
        end else begin
            strb_fall_reg <= strb_req_reg;
        end
    end

    assign serial_out      = so_reg;
    assign serial_out_oe_n = chip_select_n;

    // ************************************************************
    // Core domain: event crossing, strobes and status
    // ************************************************************
    logic [2:0]       wr_sync_reg, wr_sync_next;
    logic [2:0]       st_sync_reg, st_sync_next;
    logic             cfg_wr_valid_reg, cfg_wr_valid_next;
    scp_wr_type       cfg_wr_reg, cfg_wr_next;
    logic             strobe_valid_reg, strobe_valid_next;
    logic [5:0]       strobe_code_reg, strobe_code_next;
    logic             underflow_reg, underflow_next;
    logic [15:0]      level_cnt_reg, level_cnt_next;
    logic             level_ok_reg, level_ok_next;
    logic [7:0]       status_reg, status_next;
    logic             strobe_seen;
    logic             flush_now;

    // Holders stay still for many core cycles after their toggle
    assign strobe_seen = st_sync_reg[2] != st_sync_reg[1];
    assign flush_now   = strobe_valid_reg
                       && strobe_code_reg == `SCP_ST_FLUSH_TX;

    always_comb begin
        wr_sync_next      = {wr_sync_reg[1:0], wr_tog_reg};
        st_sync_next      = {st_sync_reg[1:0], strb_fall_reg};
        cfg_wr_valid_next = wr_sync_reg[2] != wr_sync_reg[1];
        cfg_wr_next       = cfg_wr_reg;
        if (wr_sync_reg[2] != wr_sync_reg[1]) begin
            cfg_wr_next = wr_hold_reg;
        end
        strobe_valid_next = 1'b0;
        strobe_code_next  = strobe_code_reg;
        // With the oscillator stopped only its start strobe counts
        if (strobe_seen && (crystal_running
            || strb_code_reg == `SCP_ST_OSC_START)) begin
            strobe_valid_next = 1'b1;
            strobe_code_next  = strb_code_reg;
        end
        // A new underflow beats a flush in the same cycle
        underflow_next = tx_underflow_event
                       | (underflow_reg & ~flush_now);
        level_cnt_next = level_cnt_reg;
        level_ok_next  = level_ok_reg;
        if (!rx_enabled) begin
            level_cnt_next = 16'h0000;
            level_ok_next  = 1'b0;
        end else if (level_cnt_reg == 16'(LEVEL_OK_CYCLES - 1)) begin
            level_ok_next  = 1'b1;
        end else begin
            level_cnt_next = level_cnt_reg + 16'h0001;
        end
        status_next = `SCP_SB_RESET;
        status_next[`SCP_SB_XOSC]      = crystal_running;
        status_next[`SCP_SB_UNDERFLOW] = underflow_reg;
        status_next[`SCP_SB_CIPHER]    = cipher_engine_busy;
        status_next[`SCP_SB_TX_ACTIVE] = tx_active;
        status_next[`SCP_SB_LOCK]      = pll_locked;
        status_next[`SCP_SB_LEVEL_OK]  = level_ok_reg;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_sync_reg      <= 3'h0;
            st_sync_reg      <= 3'h0;
            cfg_wr_valid_reg <= 1'b0;
            cfg_wr_reg       <= '0;
            strobe_valid_reg <= 1'b0;
            strobe_code_reg  <= `SCP_ST_NOP;
            underflow_reg    <= 1'b0;
            level_cnt_reg    <= 16'h0000;
            level_ok_reg     <= 1'b0;
            status_reg       <= `SCP_SB_RESET;
        end else begin
            wr_sync_reg      <= wr_sync_next;
            st_sync_reg      <= st_sync_next;
            cfg_wr_valid_reg <= cfg_wr_valid_next;
            cfg_wr_reg       <= cfg_wr_next;
            strobe_valid_reg <= strobe_valid_next;
            strobe_code_reg  <= strobe_code_next;
            underflow_reg    <= underflow_next;
            level_cnt_reg    <= level_cnt_next;
            level_ok_reg     <= level_ok_next;
            status_reg       <= status_next;
        end
    end

    assign cfg_wr_valid = cfg_wr_valid_reg;
    assign cfg_wr       = cfg_wr_reg;
    assign strobe_valid = strobe_valid_reg;
    assign strobe_code  = strobe_code_reg;
    assign status_byte  = status_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    a_strobe_gate: assert property (
        @(posedge clock) disable iff (sys_rst)
        strobe_valid && strobe_code != `SCP_ST_OSC_START
        |-> $past(crystal_running))
        else $error("strobe accepted with oscillator stopped");
    a_flush_clears: assert property (
        @(posedge clock) disable iff (sys_rst)
        flush_now && !tx_underflow_event
        ##1 !tx_underflow_event |=> !status_byte[`SCP_SB_UNDERFLOW])
        else $error("underflow bit survived a flush");
    a_underflow_sticky: assert property (@(posedge clock)
        disable iff (sys_rst)
        tx_underflow_event |=> ##1 status_byte[`SCP_SB_UNDERFLOW])
        else $error("underflow event not reported");
    a_level_bits: assert property (
        @(posedge clock) disable iff (sys_rst)
        status_byte[4:2] == $past({cipher_engine_busy, tx_active,
        pll_locked}) && status_byte[`SCP_SB_XOSC] == $past(crystal_running))
        else $error("status level bits do not follow inputs");
    a_reserved_zero: assert property (
        @(posedge clock) disable iff (sys_rst)
        !status_byte[7] && !status_byte[0])
        else $error("reserved status bit set");
    a_level_drop: assert property (
        @(posedge clock) disable iff (sys_rst)
        !rx_enabled |=> ##1 !status_byte[`SCP_SB_LEVEL_OK])
        else $error("signal level valid without reception");
    a_level_rise: assert property (
        @(posedge clock) disable iff (sys_rst)
        rx_enabled && level_cnt_reg == 16'(LEVEL_OK_CYCLES - 1)
        ##1 rx_enabled |=> status_byte[`SCP_SB_LEVEL_OK])
        else $error("signal level valid late");
    a_write_pulse: assert property (
        @(posedge clock) disable iff (sys_rst)
        cfg_wr_valid |=> !cfg_wr_valid && $stable(cfg_wr))
        else $error("write pulse longer than one cycle");
    a_frame_window: assert property (@(posedge serial_clock)
        disable iff (link_clr)
        bit_cnt_reg <= `SCP_FRAME_LAST)
        else $error("bit counter beyond frame");
    a_strobe_restart: assert property (@(posedge serial_clock)
        disable iff (link_clr)
        bit_cnt_reg == `SCP_HDR_LAST && strobe_hdr
        |=> bit_cnt_reg == `SCP_CNT_ZERO)
        else $error("strobe header not followed by new header");

endmodule : scp_port

`default_nettype wire

// File: tb/scp_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Host master driving the serial port
// ****************************************************************
module scp_host_model (
    output var logic serial_clock,
    output var logic chip_select_n,
    output var logic serial_in,
    input  wire logic serial_out,
    input  wire logic serial_out_oe_n
);
    // 64 ns period, 32 ns phases: inside the host's limits
    localparam time HALF = 32;

    // Undriven output reads unknown, so a stale bit never matches
    wire logic line = serial_out_oe_n ? 1'bx : serial_out;

    // Clock stands still low between frames
    initial begin
        serial_clock  = 1'b0;
        chip_select_n = 1'b1;
        serial_in     = 1'b0;
    end

    // Shift n bits MSB first; keep leaves select low for the next access
    task automatic xfer(input logic [23:0] tx, input int n, input bit keep,
                        output logic [23:0] rx);
        rx = 24'h000000;
        #3;
        if (chip_select_n) begin
            chip_select_n = 1'b0; // held low for the whole frame
            #HALF;
        end
        for (int i = 0; i < n; i++) begin
            serial_in = tx[23 - i]; // memsel first, MSB first
            #HALF serial_clock = 1'b1;
            rx = {rx[22:0], line};
            #HALF serial_clock = 1'b0;
        end
        // Released data line does not keep its last value
        serial_in = ~serial_in;
        if (!keep) begin
            #HALF chip_select_n = 1'b1;
        end
    endtask : xfer
endmodule : scp_host_model

`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Testbench top
// ****************************************************************
module tb;
    import scp_pkg::*;
    localparam int LOK = 20;
    logic       clock, sys_rst, crystal_running, cipher_engine_busy;
    logic       tx_active, pll_locked, rx_enabled, tx_underflow_event;
    logic       serial_clock, chip_select_n, serial_in;
    logic       serial_out, serial_out_oe_n, cfg_wr_valid, strobe_valid;
    scp_wr_type cfg_wr;
    logic [5:0] strobe_code;
    logic [7:0] status_byte;
    logic       uf, lv;
    int         bad_count, n_checks, cyc, n_strobe;
    scp_wr_type wr_q[$];
    logic [23:0] rx;
    logic [5:0] a[2];
    logic [15:0] d[2];
    logic [5:0] bad_a[3] = '{6'h3e, 6'h0f, 6'h31};

    scp_port #(.LEVEL_OK_CYCLES(LOK)) dut (.clock(clock), .sys_rst(sys_rst),
        .serial_clock(serial_clock), .chip_select_n(chip_select_n),
        .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe_n(serial_out_oe_n), .crystal_running(crystal_running),
        .cipher_engine_busy(cipher_engine_busy), .tx_active(tx_active),
        .pll_locked(pll_locked), .rx_enabled(rx_enabled),
        .tx_underflow_event(tx_underflow_event), .cfg_wr_valid(cfg_wr_valid),
        .cfg_wr(cfg_wr), .strobe_valid(strobe_valid),
        .strobe_code(strobe_code), .status_byte(status_byte));

    scp_host_model host (.serial_clock(serial_clock),
        .chip_select_n(chip_select_n), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Collect write and strobe pulses; a long hang ends the run
    always @(posedge clock) begin
        if (cfg_wr_valid === 1'b1) begin
            wr_q.push_back(cfg_wr);
        end
        if (strobe_valid === 1'b1) begin
            n_strobe++;
        end
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            end_sim();
        end
    end

    // Status expected from the levels the bench drives
    function automatic logic [7:0] exp_st();
        return {1'b0, crystal_running, uf, cipher_engine_busy, tx_active,
                pll_locked, lv, 1'b0};
    endfunction : exp_st

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(negedge clock);
    endtask : step

    task automatic end_sim();
        if (bad_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    // Main sequence
    initial begin
        {crystal_running, cipher_engine_busy, tx_active, pll_locked} = 4'h0;
        {rx_enabled, tx_underflow_event, uf, lv} = 4'h0;
        sys_rst = 1'b1;
        void'($urandom(32'hd9c2));
        step(10);
        sys_rst = 1'b0;
        step(3);
        check(status_byte, 8'h00);
        check(serial_out_oe_n, 1'b1);
        for (int i = 0; i < 16; i++) begin
            {crystal_running, cipher_engine_busy, tx_active, pll_locked} = 4'($urandom);
            step(3);
            check(status_byte, exp_st());
        end
        crystal_running = 1'b1;
        step(3);
        // Dummy frame primes the link copy of the status
        host.xfer(24'h000000, 8, 0, rx);
        fork
            host.xfer(24'h000000, 8, 0, rx);
            begin
                #200 check(serial_out_oe_n, 1'b0);
            end
        join
        check(rx[7:0], exp_st());
        // Back-to-back writes, boundary addresses first, then read back
        for (int it = 0; it < 3; it++) begin
            a[0] = (it == 0) ? 6'h10 : 6'h10 + 6'($urandom_range(0, 15));
            a[1] = (it == 0) ? 6'h30 : 6'h20 + 6'($urandom_range(0, 16));
            d[0] = 16'($urandom);
            d[1] = 16'($urandom);
            wr_q.delete();
            host.xfer({2'b00, a[0], d[0]}, 24, 1, rx);
            host.xfer({2'b00, a[1], d[1]}, 24, 0, rx);
            step(10);
            check(24'(wr_q.size()), 24'h2);
            for (int j = 0; j < 2; j++) begin
                check(wr_q[j], {a[j], d[j]});
                host.xfer({2'b01, a[j], 16'h0000}, 24, 0, rx);
                check(rx, {exp_st(), d[j]});
            end
        end
        // Frame cut short by select must not write
        host.xfer({2'b00, a[0], ~d[0]}, 12, 0, rx);
        step(10);
        check(24'(wr_q.size()), 24'h2);
        host.xfer({2'b01, a[0], 16'h0000}, 24, 0, rx);
        check(rx[15:0], d[0]);
        // Places outside the register range ignore writes, read zero
        foreach (bad_a[k]) begin
            host.xfer({2'b00, bad_a[k], 16'($urandom)}, 24, 0, rx);
            host.xfer({2'b01, bad_a[k], 16'h0000}, 24, 0, rx);
            check(rx[15:0], 16'h0000);
        end
        step(10);
        check(24'(wr_q.size()), 24'h2);
        // Sticky underflow; strobes gated while the crystal is off
        tx_underflow_event = 1'b1;
        step(1);
        tx_underflow_event = 1'b0;
        uf = 1'b1;
        step(20);
        check(status_byte, exp_st());
        crystal_running = 1'b0;
        n_strobe = 0;
        step(3);
        host.xfer({8'h09, 16'h0000}, 8, 0, rx);
        step(10);
        check(24'(n_strobe), 24'h0);
        check(status_byte, exp_st());
        host.xfer({8'h01, 16'h0000}, 8, 0, rx);
        step(10);
        check(24'(n_strobe), 24'h1);
        check(strobe_code, 6'h01);
        crystal_running = 1'b1;
        step(3);
        // Flush strobe followed by a read inside one select
        host.xfer({8'h09, 16'h0000}, 8, 1, rx);
        host.xfer({2'b01, a[1], 16'h0000}, 24, 0, rx);
        check(rx[15:0], d[1]);
        step(10);
        uf = 1'b0;
        check(24'(n_strobe), 24'h2);
        check(strobe_code, 6'h09);
        check(status_byte, exp_st());
        // Signal level valid after the reception time
        rx_enabled = 1'b1;
        step(LOK + 6);
        lv = 1'b1;
        check(status_byte, exp_st());
        end_sim();
    end
endmodule : tb

`default_nettype wire
